// File: include/reset_state_cfg.svh
// constants for the reset state initializer: field positions, reset values, offsets
// assumes inclusion by every design file of the block
// What this block does
// - apply source state only on reset or trap
// - software set of recovery flag changes nothing else
// - resets: memory model 0, recovery 1, fpu on
// - resets clear address mask
// - resets set supervisor mode bit
// - resets clear interrupt enable
// - resets select alternate globals
// - resets clear interrupt global select
// - resets clear mmu global select
// - trap bit and cycle counter per source
// - read-only implementation id with trap level 5
// - power-on/system: coherence bit 1, others 0
// - way and size read 0 until written
// - delayed CSR write copies to shadow at resets other than power-on
// - shadow keeps old value without reset
// - hard power-on clears both shadow and readable copy
// - cache contents kept across later entries
// - tlb contents kept across watchdog reset
// - vector offset chosen by entry source
// - fixed priority among pending reset sources
// - alt select input chooses vector base
`ifndef RESET_STATE_CFG_SVH
`define RESET_STATE_CFG_SVH

// state register field positions
`define PS_AG_BIT         0
`define PS_IE_BIT         1
`define PS_PRIV_BIT       2
`define PS_AM_BIT         3
`define PS_PEF_BIT        4
`define PS_RED_BIT        5
`define PS_MM_LSB         6
`define PS_TLE_BIT        8
`define PS_CLE_BIT        9
`define PS_MG_BIT         10
`define PS_IG_BIT         11
`define PS_WIDTH          12
`define PS_RESET_VAL      12'h0_035

// l2 control field positions
`define L2_COHERENCE_BIT  0
`define L2_ACT_WAY_BIT    2
`define L2_SIZE_BIT       4
`define L2_WIDTH          9
`define L2_RESET_VAL      9'h0_001

// vector offsets and bases
`define VEC_OFF_POR       64'h0000_0000_0000_0020
`define VEC_OFF_WDR       64'h0000_0000_0000_0040
`define VEC_OFF_XIR       64'h0000_0000_0000_0060
`define VEC_OFF_SIR       64'h0000_0000_0000_0080
`define VEC_OFF_OTHER     64'h0000_0000_0000_00a0
`define NPC_STEP          64'h0000_0000_0000_0004
`define VEC_BASE_MAIN     64'hffff_ffff_f000_0000
`define VEC_BASE_ALT      64'hffff_ffff_ffff_0000

// implementation id fields
`define ID_MAKER_CODE     16'h0_a5a  // arbitrary value
`define ID_PART_CODE      16'h0_0c3  // arbitrary value
`define ID_MAX_TRAP_LEVEL 8'h05
`define ID_MAX_WINDOW     5'h07

`define CSR_WIDTH         32
`define CSR_RESET_VAL     32'h0000_0000

`endif

// File: include/reset_state_pkg.sv
// types for the reset state initializer
// assumes nothing beyond a SystemVerilog compiler
package reset_state_pkg;

	typedef enum logic [2:0] {
		src_none,
		src_por,
		src_sys,
		src_xir,
		src_wdr,
		src_sir,
		src_trap
	} entry_src_e;

endpackage : reset_state_pkg

// File: logic/entry_arbiter.sv
// fixed-priority selection of the entry source and its trap vector
// assumes request inputs synchronous to clock
`timescale 1ns/1ps
`include "reset_state_cfg.svh"

module entry_arbiter (
	input  wire logic                        por_req,
	input  wire logic                        sys_req,
	input  wire logic                        xir_req,
	input  wire logic                        wdr_req,
	input  wire logic                        sir_req,
	input  wire logic                        trap_req,
	input  wire logic                        alt_vector_select,
	output reset_state_pkg::entry_src_e      src,
	output logic [63:0]                      vector
);

	logic [63:0] base;
	logic [63:0] off;

	assign base = alt_vector_select ? `VEC_BASE_ALT : `VEC_BASE_MAIN;

	always_comb begin
		src = reset_state_pkg::src_none;
		off = `VEC_OFF_OTHER;
		if (por_req) begin
			src = reset_state_pkg::src_por;
			off = `VEC_OFF_POR;
		end else if (sys_req) begin
			src = reset_state_pkg::src_sys;
			off = `VEC_OFF_POR;
		end else if (xir_req) begin
			src = reset_state_pkg::src_xir;
			off = `VEC_OFF_XIR;
		end else if (wdr_req) begin
			src = reset_state_pkg::src_wdr;
			off = `VEC_OFF_WDR;
		end else if (sir_req) begin
			src = reset_state_pkg::src_sir;
			off = `VEC_OFF_SIR;
		end else if (trap_req) begin
			src = reset_state_pkg::src_trap;
			off = `VEC_OFF_OTHER;
		end
	end

	assign vector = base + off;

endmodule : entry_arbiter

// File: logic/shadow_csr.sv
// delayed-effect csr: readable copy plus shadow taken at reset
// assumes load pulses are one cycle and synchronous to clock
`timescale 1ns/1ps
`include "reset_state_cfg.svh"

module shadow_csr (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    wr_en,
	input  wire logic [`CSR_WIDTH-1:0]   wr_data,
	input  wire logic                    transfer,
	input  wire logic                    hard_por,
	output logic [`CSR_WIDTH-1:0]        readable,
	output logic [`CSR_WIDTH-1:0]        shadow
);

	logic [`CSR_WIDTH-1:0] readable_r;
	logic [`CSR_WIDTH-1:0] shadow_r;

	always_ff @(posedge clock) begin
		if (rst)
			readable_r <= `CSR_RESET_VAL;
		else if (hard_por)
			readable_r <= `CSR_RESET_VAL;
		else if (wr_en)
			readable_r <= wr_data;
	end

	always_ff @(posedge clock) begin
		if (rst)
			shadow_r <= `CSR_RESET_VAL;
		else if (hard_por)
			shadow_r <= `CSR_RESET_VAL;
		else if (transfer)
			shadow_r <= readable_r;
	end
	// shadow holds otherwise

	assign readable = readable_r;
	assign shadow   = shadow_r;

endmodule : shadow_csr

// File: logic/reset_state_initializer.sv
// top of the reset state initializer: architectural state on reset and trap entries
// assumes requests are one-cycle pulses synchronous to clock; rst is the hard power-on
// assumes software writes that coincide with an entry may be dropped
`timescale 1ns/1ps
`include "reset_state_cfg.svh"

module reset_state_initializer (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     por_req,
	input  wire logic                     sys_req,
	input  wire logic                     xir_req,
	input  wire logic                     wdr_req,
	input  wire logic                     sir_req,
	input  wire logic                     trap_req,
	input  wire logic                     alt_vector_select,
	input  wire logic                     sw_red_set,
	input  wire logic                     sw_state_wr,
	input  wire logic [`PS_WIDTH-1:0]     sw_state_data,
	input  wire logic                     l2_ctl_wr,
	input  wire logic [`L2_WIDTH-1:0]     l2_ctl_data,
	input  wire logic                     csr_wr,
	input  wire logic [`CSR_WIDTH-1:0]    csr_wr_data,
	input  wire logic                     cache_wr,
	input  wire logic [3:0]               cache_idx,
	input  wire logic [15:0]              cache_data,
	input  wire logic                     tlb_wr,
	input  wire logic [3:0]               tlb_idx,
	input  wire logic [15:0]              tlb_data,
	input  wire logic [3:0]               rd_idx,
	output logic [`PS_WIDTH-1:0]          processor_state_register,
	output logic [63:0]                   cycle_counter,
	output logic                          nonprivileged_trap_bit,
	output logic [`L2_WIDTH-1:0]          l2_ctl_read,
	output logic [63:0]                   implementation_id_register,
	output logic [`CSR_WIDTH-1:0]         csr_readable,
	output logic [`CSR_WIDTH-1:0]         csr_shadow,
	output logic [63:0]                   pc,
	output logic [63:0]                   npc,
	output logic [2:0]                    entry_source,
	output logic                          entry_pulse,
	output logic [15:0]                   cache_rd_data,
	output logic [15:0]                   tlb_rd_data
);

	// ****************************************
	// entry selection
	// ****************************************
	reset_state_pkg::entry_src_e src;
	logic [63:0]                 vector;
	logic                        any_entry;
	logic                        is_hard;
	logic                        is_full;
	logic                        shadow_xfer;
	logic                        sw_ok;

	entry_arbiter u_arb (
		.por_req           (por_req),
		.sys_req           (sys_req),
		.xir_req           (xir_req),
		.wdr_req           (wdr_req),
		.sir_req           (sir_req),
		.trap_req          (trap_req),
		.alt_vector_select (alt_vector_select),
		.src               (src),
		.vector            (vector)
	);

	assign any_entry   = (src != reset_state_pkg::src_none);
	// power-on and system reset are the full entries
	assign is_full     = (src == reset_state_pkg::src_por) || (src == reset_state_pkg::src_sys);
	assign is_hard     = (src == reset_state_pkg::src_por);
	// generic traps leave the delayed csr alone; power-on clears it instead
	assign shadow_xfer = any_entry && (src != reset_state_pkg::src_trap) && !is_hard;
	// l2 control writes lose to an entry taken in the same cycle
	assign sw_ok       = !any_entry;

	// ****************************************
	// processor state register
	// ****************************************
	logic [`PS_WIDTH-1:0] ps_r;
	logic [`PS_WIDTH-1:0] ps_nxt;
	logic [`PS_WIDTH-1:0] ps_entry;

	// state left by any reset or trap entry; CLE and TLE depend on the source
	always_comb begin
		ps_entry = ps_r;
		ps_entry[`PS_MM_LSB +: 2] = 2'h0;
		ps_entry[`PS_RED_BIT]     = 1'b1;
		ps_entry[`PS_PEF_BIT]     = 1'b1;
		ps_entry[`PS_AM_BIT]      = 1'b0;
		ps_entry[`PS_PRIV_BIT]    = 1'b1;
		ps_entry[`PS_IE_BIT]      = 1'b0;
		ps_entry[`PS_AG_BIT]      = 1'b1;
		ps_entry[`PS_IG_BIT]      = 1'b0;
		ps_entry[`PS_MG_BIT]      = 1'b0;
		if (is_full) begin
			ps_entry[`PS_CLE_BIT] = 1'b0;
			ps_entry[`PS_TLE_BIT] = 1'b0;
		end else begin
			// warm entries run with the endianness that traps use
			ps_entry[`PS_CLE_BIT] = ps_r[`PS_TLE_BIT];
		end
	end

	// an entry wins over software; a bare flag set touches nothing else
	always_comb begin
		ps_nxt = ps_r;
		if (any_entry) begin
			ps_nxt = ps_entry;
		end else if (sw_red_set) begin
			ps_nxt[`PS_RED_BIT] = 1'b1;
		end else if (sw_state_wr) begin
			ps_nxt = sw_state_data;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			ps_r <= `PS_RESET_VAL;
		else
			ps_r <= ps_nxt;
	end

	// ****************************************
	// cycle counter and its trap bit
	// ****************************************
	logic [63:0] cnt_r;
	logic        npt_r;
	logic        cnt_restart;

	// watchdog, software and generic trap entries let the count run on
	assign cnt_restart = is_full || (src == reset_state_pkg::src_xir);

	always_ff @(posedge clock) begin
		if (rst)
			cnt_r <= 64'h0000_0000_0000_0000;
		else if (cnt_restart)
			cnt_r <= 64'h0000_0000_0000_0000;
		else
			cnt_r <= cnt_r + 64'h0000_0000_0000_0001;
	end

	// external, watchdog and software entries keep the bit as it was
	always_ff @(posedge clock) begin
		if (rst)
			npt_r <= 1'b1;
		else if (is_full)
			npt_r <= 1'b1;
	end

	// ****************************************
	// l2 control
	// ****************************************
	logic [`L2_WIDTH-1:0] l2_r;
	logic                 l2_written_r;
	logic [`L2_WIDTH-1:0] l2_view;

	always_ff @(posedge clock) begin
		if (rst)
			l2_r <= `L2_RESET_VAL;
		else if (is_full)
			l2_r <= `L2_RESET_VAL;
		else if (l2_ctl_wr && sw_ok)
			l2_r <= l2_ctl_data;
	end

	// set by the first write, cleared by power-on and system reset
	always_ff @(posedge clock) begin
		if (rst)
			l2_written_r <= 1'b0;
		else if (is_full)
			l2_written_r <= 1'b0;
		else if (l2_ctl_wr && sw_ok)
			l2_written_r <= 1'b1;
	end

	// way and size read back the written flag, not the stored bits
	always_comb begin
		l2_view = l2_r;
		l2_view[`L2_ACT_WAY_BIT] = l2_written_r;
		l2_view[`L2_SIZE_BIT]    = l2_written_r;
	end

	// ****************************************
	// delayed-effect csr
	// ****************************************
	logic [`CSR_WIDTH-1:0] csr_rd;
	logic [`CSR_WIDTH-1:0] csr_sh;

	// power-on clears both copies to one value; other resets move readable to shadow
	shadow_csr u_csr (
		.clock    (clock),
		.rst      (rst),
		.wr_en    (csr_wr),
		.wr_data  (csr_wr_data),
		.transfer (shadow_xfer),
		.hard_por (is_hard),
		.readable (csr_rd),
		.shadow   (csr_sh)
	);

	// ****************************************
	// cache and tlb contents, never cleared by entries
	// ****************************************
	logic [15:0] cache_mem [16];
	logic [15:0] tlb_mem   [16];

	// stores have no reset, as a power-on leaves them unknown
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_store
			always_ff @(posedge clock) begin
				if (cache_wr && cache_idx == 4'(gi))
					cache_mem[gi] <= cache_data;
				if (tlb_wr && tlb_idx == 4'(gi))
					tlb_mem[gi] <= tlb_data;
			end
		end
	endgenerate

	// ****************************************
	// program counters
	// ****************************************
	logic [63:0] pc_r;
	logic [63:0] npc_r;

	// reset itself starts execution at the power-on vector
	always_ff @(posedge clock) begin
		if (rst)
			pc_r <= `VEC_BASE_MAIN + `VEC_OFF_POR;
		else if (any_entry)
			pc_r <= vector;
	end

	// npc always runs one instruction ahead of pc
	always_ff @(posedge clock) begin
		if (rst)
			npc_r <= `VEC_BASE_MAIN + `VEC_OFF_POR + `NPC_STEP;
		else if (any_entry)
			npc_r <= vector + `NPC_STEP;
	end

	// ****************************************
	// entry report
	// ****************************************
	logic [2:0] src_r;
	logic       pulse_r;

	// source of the entry taken last cycle, zero when none
	always_ff @(posedge clock) begin
		if (rst)
			src_r <= 3'h0;
		else
			src_r <= src;
	end

	// high for the one cycle after each taken entry
	always_ff @(posedge clock) begin
		if (rst)
			pulse_r <= 1'b0;
		else
			pulse_r <= any_entry;
	end

	// ****************************************
	// l2 and csr read registers
	// ****************************************
	logic [`L2_WIDTH-1:0]  l2_out_r;
	logic [`CSR_WIDTH-1:0] csr_rd_r;
	logic [`CSR_WIDTH-1:0] csr_sh_r;

	// reset value is the view of a freshly reset l2 register
	always_ff @(posedge clock) begin
		if (rst)
			l2_out_r <= `L2_RESET_VAL;
		else
			l2_out_r <= l2_view;
	end

	always_ff @(posedge clock) begin
		if (rst)
			csr_rd_r <= `CSR_RESET_VAL;
		else
			csr_rd_r <= csr_rd;
	end

	always_ff @(posedge clock) begin
		if (rst)
			csr_sh_r <= `CSR_RESET_VAL;
		else
			csr_sh_r <= csr_sh;
	end

	// ****************************************
	// store read ports
	// ****************************************
	logic [15:0] cache_out_r;
	logic [15:0] tlb_out_r;

	// only the read register is cleared; the stores keep their contents
	always_ff @(posedge clock) begin
		if (rst)
			cache_out_r <= 16'h0000;
		else
			cache_out_r <= cache_mem[rd_idx];
	end

	always_ff @(posedge clock) begin
		if (rst)
			tlb_out_r <= 16'h0000;
		else
			tlb_out_r <= tlb_mem[rd_idx];
	end

	// ****************************************
	// identity word
	// ****************************************
	logic [63:0] id_r;

	// reloaded every cycle from constants, so it can never be changed
	always_ff @(posedge clock) begin
		id_r <= {`ID_MAKER_CODE, `ID_PART_CODE, 8'h00, `ID_MAX_TRAP_LEVEL, 11'h000,
			`ID_MAX_WINDOW};
	end

	// ****************************************
	// port drive
	// ****************************************
	// every port below comes straight from a register
	assign processor_state_register   = ps_r;
	assign cycle_counter              = cnt_r;
	assign nonprivileged_trap_bit     = npt_r;
	assign l2_ctl_read                = l2_out_r;
	assign implementation_id_register = id_r;
	assign csr_readable               = csr_rd_r;
	assign csr_shadow                 = csr_sh_r;
	assign pc                         = pc_r;
	assign npc                        = npc_r;
	assign entry_source               = src_r;
	assign entry_pulse                = pulse_r;
	assign cache_rd_data              = cache_out_r;
	assign tlb_rd_data                = tlb_out_r;

endmodule : reset_state_initializer

// File: sim/reset_source.sv
// far side model: reset pins and trap logic that raise entry requests
// assumes the bench changes arm just after a falling clock edge
`timescale 1ns/1ps

module reset_source (
	input  wire logic [5:0] arm,
	output logic            por_req,
	output logic            sys_req,
	output logic            xir_req,
	output logic            wdr_req,
	output logic            sir_req,
	output logic            trap_req
);
	// ****
	// one bit per source, highest priority first
	// ****
	assign {por_req, sys_req, xir_req, wdr_req, sir_req, trap_req} = arm;
endmodule : reset_source

// File: sim/reset_state_initializer_sva.sv
// checker for the reset state initializer, bound to its top ports
// assumes reset held several cycles before the first request
`timescale 1ns/1ps
`include "reset_state_cfg.svh"

module state_init_chk (
	input wire logic                  clock,
	input wire logic                  rst,
	input wire logic                  por_req,
	input wire logic                  sys_req,
	input wire logic                  xir_req,
	input wire logic                  wdr_req,
	input wire logic                  sir_req,
	input wire logic                  trap_req,
	input wire logic                  sw_red_set,
	input wire logic [`PS_WIDTH-1:0]  processor_state_register,
	input wire logic [63:0]           cycle_counter,
	input wire logic                  nonprivileged_trap_bit,
	input wire logic [`CSR_WIDTH-1:0] csr_shadow,
	input wire logic [63:0]           pc,
	input wire logic [63:0]           npc,
	input wire logic [2:0]            entry_source,
	input wire logic                  entry_pulse,
	input wire logic [63:0]           implementation_id_register
);
	// ****
	// properties
	// ****
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire src_w = por_req | sys_req | xir_req | wdr_req | sir_req;
	wire any_w = src_w | trap_req;
	property p_pulse; any_w |=> entry_pulse; endproperty
	a_pulse: assert property (p_pulse) else $error("no entry pulse");
	property p_quiet; !any_w |=> !entry_pulse; endproperty
	a_quiet: assert property (p_quiet) else $error("stray entry pulse");
	property p_red;
		sw_red_set && !any_w |=> processor_state_register == ($past(processor_state_register) | 12'h020);
	endproperty
	a_red: assert property (p_red) else $error("flag set disturbed state");
	property p_state; src_w |=> (processor_state_register & 12'hcff) == 12'h035; endproperty
	a_state: assert property (p_state) else $error("entry state wrong");
	property p_cnt0; por_req | sys_req | xir_req |=> cycle_counter == 64'h0; endproperty
	a_cnt0: assert property (p_cnt0) else $error("counter not restarted");
	property p_cnt;
		(wdr_req | sir_req) && !(por_req | sys_req | xir_req) |=> cycle_counter == $past(cycle_counter) + 64'h1;
	endproperty
	a_cnt: assert property (p_cnt) else $error("counter stopped");
	property p_npt; por_req | sys_req |=> nonprivileged_trap_bit; endproperty
	a_npt: assert property (p_npt) else $error("trap bit not set");
	property p_npc; entry_pulse |-> npc == pc + 64'h4; endproperty
	a_npc: assert property (p_npc) else $error("npc not pc plus four");
	property p_prio; por_req |=> entry_source == 3'h1; endproperty
	a_prio: assert property (p_prio) else $error("power-on lost priority");
	property p_shadow; !$stable(csr_shadow) |-> $past(src_w, 2); endproperty
	a_shadow: assert property (p_shadow) else $error("shadow moved without reset");
	property p_id;
		implementation_id_register[23:16] == 8'h05 && $stable(implementation_id_register);
	endproperty
	a_id: assert property (p_id) else $error("id register wrong");
endmodule : state_init_chk

bind reset_state_initializer state_init_chk chk_u (.*);

// File: sim/test_reset_state_initializer.sv
// self-checking bench for the reset state initializer
// assumes the request model and checker are compiled alongside
`timescale 1ns/1ps
`include "reset_state_cfg.svh"

module test_reset_state_initializer;
	logic                  clock, rst, alt_vector_select, sw_red_set, sw_state_wr;
	logic                  l2_ctl_wr, csr_wr, cache_wr, tlb_wr, nonprivileged_trap_bit;
	logic                  por_req, sys_req, xir_req, wdr_req, sir_req, trap_req, entry_pulse;
	logic [5:0]            arm;
	logic [`PS_WIDTH-1:0]  sw_state_data, processor_state_register;
	logic [`L2_WIDTH-1:0]  l2_ctl_data, l2_ctl_read;
	logic [`CSR_WIDTH-1:0] csr_wr_data, csr_readable, csr_shadow;
	logic [3:0]            cache_idx, tlb_idx, rd_idx;
	logic [15:0]           cache_data, tlb_data, cache_rd_data, tlb_rd_data;
	logic [63:0]           cycle_counter, implementation_id_register, pc, npc, t;
	logic [2:0]            entry_source;
	logic [63:0]           off_t [6] = '{`VEC_OFF_POR, `VEC_OFF_POR, `VEC_OFF_XIR,
		`VEC_OFF_WDR, `VEC_OFF_SIR, `VEC_OFF_OTHER};
	int                    err_total, n_checks;

	reset_source src_u (.*);
	reset_state_initializer dut_u (.*);

	// ****
	// tasks
	// ****
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] want);
		n_checks++;
		if (seen !== want) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	task automatic fire(input logic [5:0] m);
		arm = m;
		tick(1);
		arm = 6'h0;
	endtask : fire
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	initial begin
		#200000;
		err_total++;
		$display("mismatch at %0t: run too long", $time);
		close_out();
	end

	// ****
	// sequence
	// ****
	initial begin
		{alt_vector_select, sw_red_set, sw_state_wr, l2_ctl_wr, csr_wr, cache_wr, tlb_wr} = '0;
		{sw_state_data, l2_ctl_data, csr_wr_data, cache_idx, tlb_idx, rd_idx} = '0;
		{cache_data, tlb_data, arm} = '0;
		rst = 1'b1;
		tick(10);
		rst = 1'b0;
		tick(2);
		chk(processor_state_register, 12'h035);
		chk(nonprivileged_trap_bit, 1'h1);
		chk(pc, `VEC_BASE_MAIN + `VEC_OFF_POR);
		chk(implementation_id_register[23:16], 8'h05);
		chk(implementation_id_register[4:0], `ID_MAX_WINDOW);
		chk(l2_ctl_read, 9'h001);
		chk(csr_shadow, 32'h0);
		l2_ctl_wr = 1'b1;
		l2_ctl_data = 9'h1e0;
		tick(1);
		l2_ctl_wr = 1'b0;
		tick(1);
		chk(l2_ctl_read, 9'h1f4);
		fire(6'h04);
		tick(1);
		chk(l2_ctl_read, 9'h1f4);
		fire(6'h10);
		tick(1);
		chk(l2_ctl_read, 9'h001);
		csr_wr = 1'b1;
		csr_wr_data = 32'h1234_5678;
		tick(1);
		csr_wr = 1'b0;
		tick(4);
		chk(csr_readable, 32'h1234_5678);
		chk(csr_shadow, 32'h0);
		fire(6'h04);
		tick(1);
		chk(csr_shadow, 32'h1234_5678);
		fire(6'h20);
		tick(1);
		chk(csr_readable, 32'h0);
		chk(csr_shadow, 32'h0);
		{cache_wr, tlb_wr, cache_idx, tlb_idx} = {2'h3, 4'h9, 4'h9};
		{cache_data, tlb_data} = {16'h5a3c, 16'hc3a5};
		tick(1);
		{cache_wr, tlb_wr} = 2'h0;
		fire(6'h04);
		rd_idx = 4'h9;
		tick(1);
		chk(cache_rd_data, 16'h5a3c);
		chk(tlb_rd_data, 16'hc3a5);
		t = cycle_counter;
		fire(6'h04);
		chk(cycle_counter, t + 64'h1);
		tick(1);
		fire(6'h08);
		chk(cycle_counter, 64'h0);
		chk(nonprivileged_trap_bit, 1'h1);
		for (int i = 0; i < 6; i++) begin
			tick(1);
			fire(6'h3f >> i);
			chk(entry_source, i + 1);
			chk(entry_pulse, 1'h1);
		end
		for (int i = 0; i < 6; i++) begin
			alt_vector_select = i[0];
			sw_state_wr = 1'b1;
			sw_state_data = 12'hcca;
			tick(1);
			sw_state_wr = 1'b0;
			fire(6'h20 >> i);
			t = (i[0] ? `VEC_BASE_ALT : `VEC_BASE_MAIN) + off_t[i];
			chk(pc, t);
			chk(npc, t + 64'h4);
			if (i < 5)
				chk(processor_state_register & 12'hcff, 12'h035);
		end
		sw_state_wr = 1'b1;
		sw_state_data = 12'h000;
		tick(1);
		sw_state_wr = 1'b0;
		t = pc;
		sw_red_set = 1'b1;
		tick(1);
		sw_red_set = 1'b0;
		chk(processor_state_register, 12'h020);
		chk(entry_pulse, 1'h0);
		chk(pc, t);
		close_out();
	end
endmodule : test_reset_state_initializer
